// ---- amw_defs.svh ----
// Purpose: timing counts and field widths of the write sequencer
// Assumes: counts are in clk_sys periods, except maximum wait, which counts wait units
// Notes:   programmed count fields hold the wanted count minus one
`ifndef AMW_DEFS_SVH
`define AMW_DEFS_SVH

`define AMW_SETUP_W      4
`define AMW_STROBE_W     6
`define AMW_HOLD_W       3
`define AMW_MAXWAIT_W    8
`define AMW_WTU_W        9
`define AMW_TMR_W        8
`define AMW_WAIT_UNIT    16
`define AMW_RELEASE_CYC  4
`define AMW_SYNC_STAGES  3

`endif

// ---- amw_pkg.sv ----
// Purpose: shared types of the write sequencer
// Assumes: nothing beyond amw_defs.svh
// Notes:   states carry no fixed codes
package amw_pkg;
    typedef enum logic [2:0] {
        AMW_IDLE,
        AMW_SETUP,
        AMW_STROBE,
        AMW_WAIT,
        AMW_RELEASE,
        AMW_HOLD
    } amw_state_e;
endpackage

// ---- amw_tmr_if.sv ----
// Purpose: carrier between the sequencer and its phase timer
// Assumes: single clock domain
// Notes:   load takes priority over counting
`timescale 1ns/10ps
`include "amw_defs.svh"
interface amw_tmr_if;
    logic                  load;
    logic [`AMW_TMR_W-1:0] load_val;
    logic                  zero;
    modport ctl (output load, output load_val, input zero);
    modport tmr (input load, input load_val, output zero);
endinterface

// ---- amw_phase_timer.sv ----
// Purpose: down-counter that times one phase of a write cycle
// Assumes: load_val is the phase length minus one
// Notes:   zero is combinational from the count, read by the sequencer
`timescale 1ns/10ps
`include "amw_defs.svh"
module amw_phase_timer (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // control
    amw_tmr_if.tmr    tif
);
    logic [`AMW_TMR_W-1:0] cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (tif.load) begin
            cnt_ff <= tif.load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign tif.zero = (cnt_ff == '0);
endmodule

// ---- amw_top.sv ----
// Purpose: write-cycle sequencer toward an external asynchronous memory
// Assumes: request and configuration inputs are on clk_sys; memory_wait_in is a pin
// Notes:   outputs except the burst clock are registered from the next state so edges line up to the cycle
// Notes on behaviour
// - without extended wait a write lasts setup plus strobe plus hold cycles
// - without extended wait the strobe is low for exactly the strobe count
// - extended wait stretches the strobe by sixteen cycles per wait unit
// - chip select leads strobe by setup count, or falls with it in select-strobe mode
// - chip select trails strobe by hold count, or rises with it in select-strobe mode
// - address and bank valid setup cycles before strobe and hold cycles after
// - write data driven setup cycles before strobe and kept hold cycles after
// - strobe rises four cycles after the wait input is seen released
// - burst clock runs at half the interface clock in burst mode
// - counts range setup 1-16, strobe 1-64, hold 1-8, maximum wait 1-256
// - every count except maximum wait is measured in interface clock periods; maximum wait counts wait units of sixteen cycles
// - wait cycles follow the wait input and end as timeout at the limit
`timescale 1ns/10ps
`include "amw_defs.svh"
module amw_top
    import amw_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    // write request
    input  wire logic                      wr_req,
    input  wire logic                      wr_cs_index,
    input  wire logic [1:0]                wr_bank,
    input  wire logic [13:0]               wr_addr,
    input  wire logic [15:0]               wr_data,
    // configuration
    input  wire logic [`AMW_SETUP_W-1:0]   wr_setup_count,
    input  wire logic [`AMW_STROBE_W-1:0]  wr_strobe_count,
    input  wire logic [`AMW_HOLD_W-1:0]    wr_hold_count,
    input  wire logic [`AMW_MAXWAIT_W-1:0] max_wait_limit,
    input  wire logic                      extended_wait_enable,
    input  wire logic                      select_strobe_mode,
    input  wire logic                      burst_mode_enable,
    // memory pins
    input  wire logic                      memory_wait_in,
    output logic                           write_strobe_n,
    output logic [1:0]                     chip_select_n,
    output logic [1:0]                     bank_select,
    output logic [13:0]                    mem_address,
    output logic [15:0]                    mem_data_out,
    output logic                           mem_data_oe,
    output logic                           burst_clock_out,
    // status
    output logic                           busy,
    output logic                           write_done,
    output logic                           wait_timeout,
    output logic [`AMW_WTU_W-1:0]          observed_wait_cycles
);
    amw_tmr_if tif ();

    amw_phase_timer u_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tif     (tif)
    );

    amw_state_e                      state_ff;
    amw_state_e                      nxt_state;
    logic [`AMW_SYNC_STAGES-1:0]     wait_sync_ff;
    logic                            wait_seen_ff;
    logic                            cs_index_ff;
    logic                            write_strobe_n_ff;
    logic [1:0]                      chip_select_n_ff;
    logic [1:0]                      bank_select_ff;
    logic [13:0]                     mem_address_ff;
    logic [15:0]                     mem_data_out_ff;
    logic                            mem_data_oe_ff;
    logic                            burst_clock_out_ff;
    logic                            busy_ff;
    logic                            write_done_ff;
    logic                            wait_timeout_ff;
    logic [`AMW_WTU_W-1:0]           wtu_ff;
    logic                            nxt_timeout;
    logic                            nxt_wtu_inc;
    logic                            strobe_on;
    logic                            cs_on;

    // pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wait_sync_ff <= '0;
            wait_seen_ff <= 1'b0;
        end else begin
            wait_sync_ff <= {wait_sync_ff[`AMW_SYNC_STAGES-2:0], memory_wait_in};
            if (wait_sync_ff[1] == wait_sync_ff[2]) begin
                wait_seen_ff <= wait_sync_ff[2];
            end
        end
    end

    // phase sequencing; each load value is the phase length minus one
    always_comb begin
        nxt_state     = state_ff;
        tif.load      = 1'b0;
        tif.load_val  = '0;
        nxt_timeout   = 1'b0;
        nxt_wtu_inc   = 1'b0;
        unique case (state_ff)
            AMW_IDLE: begin
                if (wr_req) begin
                    nxt_state    = AMW_SETUP;
                    tif.load     = 1'b1;
                    tif.load_val = `AMW_TMR_W'(wr_setup_count);
                end
            end
            AMW_SETUP: begin
                if (tif.zero) begin
                    nxt_state    = AMW_STROBE;
                    tif.load     = 1'b1;
                    tif.load_val = `AMW_TMR_W'(wr_strobe_count);
                end
            end
            AMW_STROBE: begin
                if (tif.zero) begin
                    tif.load = 1'b1;
                    if (extended_wait_enable && wait_seen_ff) begin
                        nxt_state    = AMW_WAIT;
                        tif.load_val = `AMW_TMR_W'(`AMW_WAIT_UNIT - 1);
                    end else begin
                        nxt_state    = AMW_HOLD;
                        tif.load_val = `AMW_TMR_W'(wr_hold_count);
                    end
                end
            end
            AMW_WAIT: begin
                if (!wait_seen_ff) begin
                    nxt_state    = AMW_RELEASE;
                    tif.load     = 1'b1;
                    tif.load_val = `AMW_TMR_W'(`AMW_RELEASE_CYC - 1);
                end else if (tif.zero) begin
                    nxt_wtu_inc = 1'b1;
                    tif.load    = 1'b1;
                    // limit field holds maximum minus one, so compare before the increment
                    if (wtu_ff == `AMW_WTU_W'(max_wait_limit)) begin
                        nxt_timeout  = 1'b1;
                        nxt_state    = AMW_HOLD;
                        tif.load_val = `AMW_TMR_W'(wr_hold_count);
                    end else begin
                        tif.load_val = `AMW_TMR_W'(`AMW_WAIT_UNIT - 1);
                    end
                end
            end
            AMW_RELEASE: begin
                if (tif.zero) begin
                    nxt_state    = AMW_HOLD;
                    tif.load     = 1'b1;
                    tif.load_val = `AMW_TMR_W'(wr_hold_count);
                end
            end
            AMW_HOLD: begin
                if (tif.zero) begin
                    nxt_state = AMW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_ff <= AMW_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign strobe_on = (nxt_state == AMW_STROBE) || (nxt_state == AMW_WAIT) || (nxt_state == AMW_RELEASE);
    assign cs_on     = select_strobe_mode ? strobe_on : (nxt_state != AMW_IDLE);

    // pin drive registered from the next state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            write_strobe_n_ff <= 1'b1;
            chip_select_n_ff  <= 2'h3;
            mem_data_oe_ff    <= 1'b0;
            busy_ff           <= 1'b0;
        end else begin
            write_strobe_n_ff <= !strobe_on;
            chip_select_n_ff  <= cs_on ? (cs_index_next() ? 2'h1 : 2'h2) : 2'h3;
            mem_data_oe_ff    <= (nxt_state != AMW_IDLE);
            busy_ff           <= (nxt_state != AMW_IDLE);
        end
    end

    function automatic logic cs_index_next();
        cs_index_next = (state_ff == AMW_IDLE) ? wr_cs_index : cs_index_ff;
    endfunction

    // address, bank and data latched at acceptance and held through hold phase
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cs_index_ff     <= 1'b0;
            bank_select_ff  <= 2'h0;
            mem_address_ff  <= 14'h0000;
            mem_data_out_ff <= 16'h0000;
        end else if (state_ff == AMW_IDLE && wr_req) begin
            cs_index_ff     <= wr_cs_index;
            bank_select_ff  <= wr_bank;
            mem_address_ff  <= wr_addr;
            mem_data_out_ff <= wr_data;
        end
    end

    // wait accounting and completion status
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wtu_ff          <= '0;
            write_done_ff   <= 1'b0;
            wait_timeout_ff <= 1'b0;
        end else begin
            if (state_ff == AMW_IDLE && wr_req) begin
                wtu_ff <= '0;
            end else if (nxt_wtu_inc) begin
                wtu_ff <= wtu_ff + 1'b1;
            end
            write_done_ff   <= (state_ff == AMW_HOLD) && (nxt_state == AMW_IDLE);
            wait_timeout_ff <= nxt_timeout;
        end
    end

    // burst clock toggles every edge, giving half the interface clock
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            burst_clock_out_ff <= 1'b0;
        end else if (burst_mode_enable) begin
            burst_clock_out_ff <= !burst_clock_out_ff;
        end else begin
            burst_clock_out_ff <= 1'b0;
        end
    end

    assign write_strobe_n       = write_strobe_n_ff;
    assign chip_select_n        = chip_select_n_ff;
    assign bank_select          = bank_select_ff;
    assign mem_address          = mem_address_ff;
    assign mem_data_out         = mem_data_out_ff;
    assign mem_data_oe          = mem_data_oe_ff;
    assign burst_clock_out      = burst_clock_out_ff;
    assign busy                 = busy_ff;
    assign write_done           = write_done_ff;
    assign wait_timeout         = wait_timeout_ff;
    assign observed_wait_cycles = wtu_ff;
endmodule

// ---- amw_chk.sv ----
// Purpose: pin timing checks of the write sequencer
// Assumes: configuration stays steady during a write
// Notes:   counters measure phase lengths in clk_sys cycles
`timescale 1ns/10ps
`include "amw_defs.svh"
module amw_chk (
    // clock and reset
    input wire logic                     clk_sys,
    input wire logic                     resetn,
    // configuration
    input wire logic [`AMW_SETUP_W-1:0]  wr_setup_count,
    input wire logic [`AMW_STROBE_W-1:0] wr_strobe_count,
    input wire logic [`AMW_HOLD_W-1:0]   wr_hold_count,
    input wire logic                     extended_wait_enable,
    input wire logic                     select_strobe_mode,
    input wire logic                     burst_mode_enable,
    // pins and status
    input wire logic                     memory_wait_in,
    input wire logic                     write_strobe_n,
    input wire logic [1:0]               chip_select_n,
    input wire logic                     mem_data_oe,
    input wire logic                     burst_clock_out,
    input wire logic                     busy,
    input wire logic                     write_done
);
    logic [9:0] lo_ff, cs_ff, hd_ff, bz_ff;
    // hold counter restarts on strobe low, so setup cycles never leak into it
    always_ff @(posedge clk_sys) begin
        lo_ff <= write_strobe_n ? 10'h000 : lo_ff + 10'h001;
        cs_ff <= &chip_select_n ? 10'h000 : cs_ff + 10'h001;
        hd_ff <= (write_strobe_n && !(&chip_select_n)) ? hd_ff + 10'h001 : 10'h000;
        bz_ff <= busy ? bz_ff + 10'h001 : 10'h000;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    chk_strobe_width: assert property (
        $rose(write_strobe_n) && !extended_wait_enable |-> lo_ff == wr_strobe_count + 1
    ) else $error("strobe width wrong");
    chk_setup_lead: assert property (
        $fell(write_strobe_n) |-> cs_ff == (select_strobe_mode ? 0 : wr_setup_count + 1)
    ) else $error("select lead wrong");
    chk_hold_trail: assert property (
        $rose(&chip_select_n) |-> hd_ff == (select_strobe_mode ? 0 : wr_hold_count + 1)
    ) else $error("select trail wrong");
    chk_cycle_len: assert property (
        $fell(busy) && !extended_wait_enable |-> bz_ff == wr_setup_count + wr_strobe_count + wr_hold_count + 3
    ) else $error("cycle length wrong");
    chk_done_pulse: assert property (
        $fell(busy) |-> write_done ##1 !write_done
    ) else $error("done pulse wrong");
    chk_strobe_in_cs: assert property (
        !write_strobe_n |-> busy && mem_data_oe && (chip_select_n == 2'b10 || chip_select_n == 2'b01)
    ) else $error("strobe outside select");
    chk_wait_release: assert property (
        $fell(memory_wait_in) && extended_wait_enable && !write_strobe_n |-> (!write_strobe_n)[*4] ##[1:6] write_strobe_n
    ) else $error("release delay wrong");
    chk_burst_toggle: assert property (
        burst_mode_enable && $past(burst_mode_enable) |-> burst_clock_out != $past(burst_clock_out)
    ) else $error("burst clock stuck");
endmodule
bind amw_top amw_chk u_chk (.clk_sys, .resetn, .wr_setup_count, .wr_strobe_count, .wr_hold_count,
    .extended_wait_enable, .select_strobe_mode, .burst_mode_enable, .memory_wait_in, .write_strobe_n,
    .chip_select_n, .mem_data_oe, .burst_clock_out, .busy, .write_done);

// ---- amw_mem_model.sv ----
// Purpose: external memory that stalls writes through its wait pin
// Assumes: wait pin has a pull-down
// Notes:   busy_cycles of zero gives a memory that never stalls
`timescale 1ns/10ps
module amw_mem_model (
    // clock
    input  wire logic       clk_sys,
    // memory pins
    input  wire logic       write_strobe_n,
    input  wire logic [1:0] chip_select_n,
    output logic            memory_wait_in,
    // behaviour
    input  wire logic [8:0] busy_cycles
);
    logic [8:0] cnt_ff;
    always_ff @(posedge clk_sys) begin
        cnt_ff <= write_strobe_n ? 9'h000 : cnt_ff + 9'h001;
    end
    // released outside a strobe, so the pull-down wins
    assign memory_wait_in = !write_strobe_n && !(&chip_select_n) && (cnt_ff < busy_cycles);
endmodule

// ---- tb_top.sv ----
// Purpose: directed write cycles against the sequencer and a memory model
// Assumes: inputs change on the falling edge
// Notes:   wait lengths land mid-unit, clear of synchroniser jitter
`timescale 1ns/10ps
`include "amw_defs.svh"
module tb_top;
    logic                      clk_sys = 1'b0;
    logic                      resetn, wr_req, wr_cs_index, extended_wait_enable, select_strobe_mode;
    logic                      burst_mode_enable, memory_wait_in, write_strobe_n, mem_data_oe;
    logic                      burst_clock_out, busy, write_done, wait_timeout, b0;
    logic [1:0]                wr_bank, chip_select_n, bank_select;
    logic [13:0]               wr_addr, mem_address;
    logic [15:0]               wr_data, mem_data_out;
    logic [`AMW_SETUP_W-1:0]   wr_setup_count;
    logic [`AMW_STROBE_W-1:0]  wr_strobe_count;
    logic [`AMW_HOLD_W-1:0]    wr_hold_count;
    logic [`AMW_MAXWAIT_W-1:0] max_wait_limit;
    logic [`AMW_WTU_W-1:0]     observed_wait_cycles, wait_len;
    int                        n_errors = 0;
    int                        samples_checked = 0;

    always #25 clk_sys = ~clk_sys;

    amw_top DUT (.clk_sys, .resetn, .wr_req, .wr_cs_index, .wr_bank, .wr_addr, .wr_data, .wr_setup_count,
        .wr_strobe_count, .wr_hold_count, .max_wait_limit, .extended_wait_enable, .select_strobe_mode,
        .burst_mode_enable, .memory_wait_in, .write_strobe_n, .chip_select_n, .bank_select, .mem_address,
        .mem_data_out, .mem_data_oe, .burst_clock_out, .busy, .write_done, .wait_timeout, .observed_wait_cycles);
    amw_mem_model u_mem (.clk_sys, .write_strobe_n, .chip_select_n, .memory_wait_in, .busy_cycles(wait_len));

    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_write(input logic cs, input logic [3:0] s, input logic [5:0] t, input logic [2:0] h,
                            input logic ss, input logic xw, input logic [8:0] wl, input logic [8:0] units,
                            input logic to);
        int   nb;
        int   sl;
        int   cl;
        logic to_seen;
        @(negedge clk_sys);
        {wr_cs_index, wr_setup_count, wr_strobe_count, wr_hold_count} = {cs, s, t, h};
        {select_strobe_mode, extended_wait_enable, wait_len, wr_req} = {ss, xw, wl, 1'b1};
        wr_bank = {cs, ~cs};
        wr_addr = {s, t, h, ~cs};
        wr_data = {t, s, ~h, ss, xw, cs};
        nb = 0;
        sl = 0;
        cl = 0;
        to_seen = 1'b0;
        @(negedge clk_sys);
        wr_req = 1'b0;
        while (busy === 1'b1 && nb < 2000) begin
            nb++;
            if (write_strobe_n === 1'b0) sl++;
            if (chip_select_n !== 2'b11) cl++;
            if (wait_timeout === 1'b1) to_seen = 1'b1;
            // word and drive must hold through setup, strobe and hold alike
            compare({bank_select, mem_address, mem_data_out}, {wr_bank, wr_addr, wr_data}, "word");
            compare(mem_data_oe, 1'b1, "drive");
            if (write_strobe_n === 1'b0 && sl == 1) begin
                compare({mem_data_oe, chip_select_n}, {1'b1, ~cs, cs}, "select");
            end
            @(negedge clk_sys);
        end
        compare(write_done, 1'b1, "done");
        compare(observed_wait_cycles, units, "wait units");
        compare(to_seen, to, "timeout");
        if (wl == 9'h000) begin
            compare(nb, s + t + h + 3, "cycle length");
            compare(sl, t + 1, "strobe width");
            compare(cl, ss ? t + 1 : s + t + h + 3, "select width");
        end
    endtask

    initial begin
        {resetn, wr_req, wr_cs_index, extended_wait_enable, select_strobe_mode, burst_mode_enable} = '0;
        {wr_bank, wr_addr, wr_data, wr_setup_count, wr_strobe_count, wr_hold_count} = '0;
        max_wait_limit = 8'h05;
        wait_len = 9'h000;
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        compare({busy, write_strobe_n, chip_select_n, mem_data_oe}, 5'b01110, "reset");
        do_write(1'b0, 4'h0, 6'h00, 3'h0, 1'b0, 1'b0, 9'h000, 9'h000, 1'b0);
        do_write(1'b1, 4'hF, 6'h3F, 3'h7, 1'b0, 1'b0, 9'h000, 9'h000, 1'b0);
        do_write(1'b0, 4'h2, 6'h03, 3'h1, 1'b1, 1'b0, 9'h000, 9'h000, 1'b0);
        do_write(1'b1, 4'h0, 6'h00, 3'h0, 1'b1, 1'b1, 9'h000, 9'h000, 1'b0);
        do_write(1'b0, 4'h1, 6'h07, 3'h2, 1'b0, 1'b1, 9'h028, 9'h002, 1'b0);
        max_wait_limit = 8'h00;
        do_write(1'b1, 4'h1, 6'h07, 3'h0, 1'b0, 1'b1, 9'h0C8, 9'h001, 1'b1);
        burst_mode_enable = 1'b1;
        repeat (2) @(negedge clk_sys);
        b0 = burst_clock_out;
        @(negedge clk_sys);
        compare(burst_clock_out, !b0, "burst clock");
        print_verdict();
    end

    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end
endmodule
